//--- cpu_partner_model.sv
// CPU core model: takes presented interrupts, stacks the master flag, returns on command
`timescale 1ns/1ps
`include "irq_ctrl_regs.svh"
module cpu_partner_model import irq_ctrl_pkg::*; (
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  input  wire logic       request_in,
  input  wire logic       saved_in,
  input  wire logic [2:0] wait_in,
  input  wire logic       ret_cmd_in,
  output logic            accept_out,
  output logic            return_out,
  output logic            restored_out
);
  logic stack_q[$];
  int   cnt;
  int   busy;
  logic a;
  logic rt;
  logic rv;
  // Accept after wait_in cycles; no new accept while the push sequence runs
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      accept_out <= 1'b0;
      return_out <= 1'b0;
      restored_out <= 1'b0;
      cnt = 0;
      busy = 0;
      stack_q.delete();
    end else begin
      a = 1'b0;
      rt = 1'b0;
      rv = ~restored_out; // Released line must not keep its last value
      if (busy > 0) begin
        busy = busy - 1;
        if (busy == `ACCEPT_MACHINE_CYCLES - 2) stack_q.push_back(saved_in);
      end else if (request_in && cnt >= wait_in) begin
        a = 1'b1;
        cnt = 0;
        busy = `ACCEPT_MACHINE_CYCLES;
      end else begin
        cnt = request_in ? cnt + 1 : 0;
      end
      if (ret_cmd_in && stack_q.size() > 0 && busy == 0) begin
        rt = 1'b1;
        rv = stack_q.pop_back();
      end
      accept_out <= a;
      return_out <= rt;
      restored_out <= rv;
    end
  end
endmodule

//--- fix_note_unused.sv
// Intentionally empty

//--- irq_ctrl_pkg.sv
// Types and the vector helper function shared by the interrupt controller files
package irq_ctrl_pkg;
  `include "irq_ctrl_regs.svh"

  typedef logic [3:0]  src_idx_t;
  typedef logic [15:0] vector_t;

  // Vector of a source index: two bytes per step below the reset vector
  function automatic vector_t vector_of(input src_idx_t idx);
    vector_of = `TOP_VECTOR - {11'h000, idx, 1'b0};
  endfunction

  // Arbiter state
  typedef struct packed {
    logic     hit_ff;
    src_idx_t idx_ff;
  } pick_s;

  // Register-read port state
  typedef struct packed {
    logic [7:0] rdata_ff;
  } sfr_s;

  // Controller state
  typedef struct packed {
    logic [15:0] latch_ff;
    logic [15:0] enable_ff;
    logic        master_ff;
    logic        choice_ff;
    logic        req_ff;
    src_idx_t    idx_ff;
    vector_t     vec_ff;
    logic        saved_master_ff;
  } ctrl_s;
endpackage

//--- irq_ctrl_regs.svh
// Register offsets, field positions, reset values and constants of the interrupt controller
// How it works
// (R1) Source request sets its latch; enabled asks CPU
// (R2) Acceptance clears the serviced source's latch
// (R3) Reset clears every request latch
// (R4) Software writes of one never set latches
// (R5) Latches readable at two bytes, individually clearable
// (R6) Software keeps trap and watchdog latches set
// (R7) Software clears latches with plain loads
// (R8) Master flag low blocks all maskable sources
// (R9) Acceptance saves master flag, then clears it
// (R10) Return instructions reload saved master flag
// (R11) Master flag is bit 0, resets low
// (R12) Enable flags 4 to 15 gate, reset low
// (R13) Non-maskable sources ignore every enable flag
// (R14) Fixed priority among maskables; non-maskables unranked, here ranked by index too
// (R15) Vectors FFFC shared, FFFA trap, FFF8 watchdog
// (R16) Maskable vectors FFF6 down to FFE0
// (R17) Selector bit picks timer four or external three
// (R18) Unselected shared source requests are discarded
// (R19) Software sets selector before shared sources fire
// (R20) Software writes zero to selector bit 5
// (R21) Software drops master flag around flag edits; the bench leaves it as it is
// (R22) Enable bytes survive read-modify-write bit operations
// (R23) Trap and watchdog pass only when selected
// (R24) Latched request holds until accepted or cleared
// (R25) Acceptance follows instruction end, eight machine cycles
// (R26) Maskable request needs latch, flag, master, extra
`ifndef IRQ_CTRL_REGS_SVH
`define IRQ_CTRL_REGS_SVH

`define ENABLE_LOW_ADDR   8'h3A
`define ENABLE_HIGH_ADDR  8'h3B
`define PENDING_LOW_ADDR  8'h3C
`define PENDING_HIGH_ADDR 8'h3D
`define SRC_SELECT_ADDR   8'h3E

`define MASTER_BIT        0
`define LEVEL12_CHOICE_BIT 4
`define SELECT_FORBIDDEN_BIT 5

`define LATCH_RESET       16'h0000
`define ENABLE_RESET      16'h0000
`define MASTER_RESET      1'b0
`define CHOICE_RESET      1'b0

`define TOP_VECTOR        16'hFFFE
`define TRAP_LATCH        4'h2
`define WATCHDOG_LATCH    4'h3
`define FIRST_MASKABLE    4'h4
`define SHARED_LATCH      4'hB

`define ACCEPT_MACHINE_CYCLES 8

`endif

//--- irq_priority_pick.sv
// Fixed-priority pick of the lowest numbered active request
`timescale 1ns/1ps
module irq_priority_pick import irq_ctrl_pkg::*; (
  input  wire logic [15:0] active_in,
  output logic             hit_out,
  output src_idx_t         idx_out
);
  pick_s cur;

  // Lowest index wins, also among the non-maskable sources 1..3
  always_comb begin
    cur.hit_ff = 1'b0;
    cur.idx_ff = 4'h0;
    for (int i = 15; i >= 1; i--) begin
      if (active_in[i]) begin // R14
        cur.hit_ff = 1'b1;
        cur.idx_ff = src_idx_t'(i);
      end
    end
  end

  assign hit_out = cur.hit_ff;
  assign idx_out = cur.idx_ff;
endmodule

//--- irq_sfr_port.sv
// Register-read multiplexer with a registered read data output
`timescale 1ns/1ps
`include "irq_ctrl_regs.svh"
module irq_sfr_port import irq_ctrl_pkg::*; (
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  input  wire logic        rd_in,
  input  wire logic [7:0]  addr_in,
  input  wire logic [15:0] latch_in,
  input  wire logic [15:0] enable_in,
  input  wire logic        master_in,
  input  wire logic        choice_in,
  output logic [7:0]       rdata_out
);
  sfr_s cur_ff;
  sfr_s nxt_cur;

  // Reserved bits read zero; data held between reads
  always_comb begin
    nxt_cur = cur_ff;
    if (rd_in) begin
      case (addr_in)
        `ENABLE_LOW_ADDR:   nxt_cur.rdata_ff = {enable_in[7:4], 3'h0, master_in}; // R11
        `ENABLE_HIGH_ADDR:  nxt_cur.rdata_ff = enable_in[15:8];
        `PENDING_LOW_ADDR:  nxt_cur.rdata_ff = {latch_in[7:2], 2'h0}; // R5
        `PENDING_HIGH_ADDR: nxt_cur.rdata_ff = latch_in[15:8]; // R5
        `SRC_SELECT_ADDR:   nxt_cur.rdata_ff = {3'h0, choice_in, 4'h0};
        default:            nxt_cur.rdata_ff = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cur_ff <= '0;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  assign rdata_out = cur_ff.rdata_ff;
endmodule

//--- prioritized_interrupt_controller.sv
// Interrupt latches, enable flags, source select and CPU request logic
`timescale 1ns/1ps
`include "irq_ctrl_regs.svh"
module prioritized_interrupt_controller import irq_ctrl_pkg::*; (
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  // Special-function register access
  input  wire logic [7:0]  sfr_addr_in,
  input  wire logic        sfr_wr_in,
  input  wire logic        sfr_rd_in,
  input  wire logic [7:0]  sfr_wdata_in,
  output logic [7:0]       sfr_rdata_out,
  // CPU handshake
  input  wire logic        master_on_instr_in,
  input  wire logic        master_off_instr_in,
  input  wire logic        return_instr_in,
  input  wire logic        restored_master_in,
  input  wire logic        irq_accept_in,
  output logic             irq_request_out,
  output logic [15:0]      irq_vector_out,
  output logic [3:0]       irq_source_out,
  output logic             saved_master_out,
  // Non-maskable sources
  input  wire logic        software_trap_irq_in,
  input  wire logic        bad_opcode_irq_in,
  input  wire logic        fetch_area_trap_irq_in,
  input  wire logic        trap_output_select_in,
  input  wire logic        watchdog_irq_in,
  input  wire logic        watchdog_output_select_in,
  // Maskable sources
  input  wire logic        ext_irq_zero_in,
  input  wire logic        ext_zero_pin_enable_in,
  input  wire logic        ext_irq_one_in,
  input  wire logic        time_base_irq_in,
  input  wire logic        timer1_irq_in,
  input  wire logic        serial_receive_irq_in,
  input  wire logic        serial_transmit_irq_in,
  input  wire logic        timer3_irq_in,
  input  wire logic        timer4_irq_in,
  input  wire logic        ext_irq_three_in,
  input  wire logic        converter_done_irq_in,
  input  wire logic        serial_expansion_irq_in,
  input  wire logic        ext_irq_four_in,
  input  wire logic        ext_irq_five_in
);
  ctrl_s       cur_ff;
  ctrl_s       nxt_cur;
  logic [15:0] set_vec;
  logic [15:0] active;
  logic        pick_hit;
  src_idx_t    pick_idx;
  logic        accept;
  logic        wr_en_low;
  logic        wr_en_high;
  logic        wr_pend_low;
  logic        wr_pend_high;
  logic        wr_select;

  // One write strobe per register; shared so every decode reads alike
  function automatic logic wr_hit(input logic       wr,
                                  input logic [7:0] addr,
                                  input logic [7:0] target);
    wr_hit = wr && (addr == target);
  endfunction

  // Hardware set requests per latch; bits 0 and 1 have no latch
  always_comb begin
    set_vec     = 16'h0000;
    set_vec[2]  = fetch_area_trap_irq_in & ~trap_output_select_in; // R23
    set_vec[3]  = watchdog_irq_in & ~watchdog_output_select_in; // R23
    set_vec[4]  = ext_irq_zero_in;
    set_vec[5]  = ext_irq_one_in;
    set_vec[6]  = time_base_irq_in;
    set_vec[7]  = timer1_irq_in;
    set_vec[8]  = serial_receive_irq_in;
    set_vec[9]  = serial_transmit_irq_in;
    set_vec[10] = timer3_irq_in;
    // Unselected partner is dropped, never latched
    set_vec[11] = cur_ff.choice_ff ? ext_irq_three_in : timer4_irq_in; // R17 R18
    set_vec[12] = converter_done_irq_in;
    set_vec[13] = serial_expansion_irq_in;
    set_vec[14] = ext_irq_four_in;
    set_vec[15] = ext_irq_five_in;
  end

  // Requests offered to the arbiter
  always_comb begin
    active    = 16'h0000;
    active[1] = software_trap_irq_in | bad_opcode_irq_in; // R15
    active[2] = cur_ff.latch_ff[2]; // R13
    active[3] = cur_ff.latch_ff[3]; // R13
    // Maskable: latch, own flag, master flag, plus pin enable for source 4
    active[15:4] = cur_ff.latch_ff[15:4] & cur_ff.enable_ff[15:4]
                   & {12{cur_ff.master_ff}}; // R8 R12 R26
    active[4] = active[4] & ext_zero_pin_enable_in; // R26
  end

  irq_priority_pick u_pick (
    .active_in (active),
    .hit_out   (pick_hit),
    .idx_out   (pick_idx)
  );

  // Register write strobes
  assign wr_en_low    = wr_hit(sfr_wr_in, sfr_addr_in, `ENABLE_LOW_ADDR);
  assign wr_en_high   = wr_hit(sfr_wr_in, sfr_addr_in, `ENABLE_HIGH_ADDR);
  assign wr_pend_low  = wr_hit(sfr_wr_in, sfr_addr_in, `PENDING_LOW_ADDR);
  assign wr_pend_high = wr_hit(sfr_wr_in, sfr_addr_in, `PENDING_HIGH_ADDR);
  assign wr_select    = wr_hit(sfr_wr_in, sfr_addr_in, `SRC_SELECT_ADDR);
  assign accept       = irq_accept_in && cur_ff.req_ff;

  // Next state; within a cycle the hardware set always wins over any clear
  always_comb begin
    nxt_cur = cur_ff;
    // Writes only clear: a one leaves the latch as it was
    if (wr_pend_low) begin
      nxt_cur.latch_ff[7:2] = cur_ff.latch_ff[7:2] & sfr_wdata_in[7:2]; // R4 R5
    end
    if (wr_pend_high) begin
      nxt_cur.latch_ff[15:8] = cur_ff.latch_ff[15:8] & sfr_wdata_in; // R4 R5
    end
    if (accept && (cur_ff.idx_ff >= `TRAP_LATCH)) begin
      nxt_cur.latch_ff[cur_ff.idx_ff] = 1'b0; // R2
    end
    nxt_cur.latch_ff = (nxt_cur.latch_ff | set_vec) & 16'hFFFC; // R1 R24
    // Enable flags are plain storage, so bit operations are safe
    if (wr_en_low) begin
      nxt_cur.enable_ff[7:4] = sfr_wdata_in[7:4]; // R12 R22
      nxt_cur.master_ff      = sfr_wdata_in[`MASTER_BIT]; // R11
    end
    if (wr_en_high) begin
      nxt_cur.enable_ff[15:8] = sfr_wdata_in; // R12 R22
    end
    if (wr_select) begin
      nxt_cur.choice_ff = sfr_wdata_in[`LEVEL12_CHOICE_BIT]; // R17
    end
    if (master_on_instr_in) begin
      nxt_cur.master_ff = 1'b1; // R11
    end
    if (master_off_instr_in) begin
      nxt_cur.master_ff = 1'b0; // R11
    end
    if (return_instr_in) begin
      nxt_cur.master_ff = restored_master_in; // R10
    end
    // Acceptance outranks every other master flag change
    if (accept) begin
      nxt_cur.saved_master_ff = cur_ff.master_ff; // R9
      nxt_cur.master_ff       = 1'b0; // R9 R25
    end
    // Registered request; one-cycle lag behind flag changes
    nxt_cur.req_ff = pick_hit;
    nxt_cur.idx_ff = pick_idx; // R14
    nxt_cur.vec_ff = pick_hit ? vector_of(pick_idx) : cur_ff.vec_ff; // R15 R16
  end

  // Reset clears latches, flags and the request
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cur_ff.latch_ff        <= `LATCH_RESET; // R3
      cur_ff.enable_ff       <= `ENABLE_RESET; // R12
      cur_ff.master_ff       <= `MASTER_RESET; // R11
      cur_ff.choice_ff       <= `CHOICE_RESET;
      cur_ff.req_ff          <= 1'b0;
      cur_ff.idx_ff          <= 4'h0;
      cur_ff.vec_ff          <= `TOP_VECTOR;
      cur_ff.saved_master_ff <= 1'b0;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  irq_sfr_port u_sfr (
    .clk_in    (clk_in),
    .rst_n_in  (rst_n_in),
    .rd_in     (sfr_rd_in),
    .addr_in   (sfr_addr_in),
    .latch_in  (cur_ff.latch_ff),
    .enable_in (cur_ff.enable_ff),
    .master_in (cur_ff.master_ff),
    .choice_in (cur_ff.choice_ff),
    .rdata_out (sfr_rdata_out)
  );

  assign irq_request_out  = cur_ff.req_ff;
  assign irq_vector_out   = cur_ff.vec_ff;
  assign irq_source_out   = cur_ff.idx_ff;
  assign saved_master_out = cur_ff.saved_master_ff;

  // Checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  sequence s_accept;
    irq_accept_in && cur_ff.req_ff;
  endsequence

  sequence s_plain_return;
    return_instr_in && !irq_accept_in && !master_on_instr_in;
  endsequence

  a_latch_sets: assert property (set_vec[9] |=> cur_ff.latch_ff[9]) // R1
    else $error("source request did not set its latch");
  a_accept_clears: assert property (s_accept ##0 (cur_ff.idx_ff == 4'h6) && !set_vec[6]
    |=> !cur_ff.latch_ff[6]) // R2
    else $error("accepted latch not cleared");
  a_write_one_ignored: assert property (wr_pend_low && (set_vec[7:2] == 6'h00)
    |=> (cur_ff.latch_ff[7:2] & ~$past(cur_ff.latch_ff[7:2])) == 6'h00) // R4
    else $error("software write set a latch");
  a_master_blocks: assert property (!cur_ff.master_ff
    |=> !(cur_ff.req_ff && (cur_ff.idx_ff >= `FIRST_MASKABLE))) // R8
    else $error("maskable request with master flag low");
  a_accept_saves: assert property (s_accept
    |=> (saved_master_out == $past(cur_ff.master_ff)) && !cur_ff.master_ff) // R9
    else $error("master flag not saved and cleared");
  a_return_reload: assert property (s_plain_return
    |=> cur_ff.master_ff == $past(restored_master_in)) // R10
    else $error("return did not reload master flag");
  a_nonmask_pass: assert property ((cur_ff.latch_ff[2] || cur_ff.latch_ff[3])
    |=> irq_request_out && (irq_source_out <= `WATCHDOG_LATCH)) // R13
    else $error("non-maskable request not presented");
  a_vector_map: assert property (irq_request_out
    |-> irq_vector_out == `TOP_VECTOR - {11'h000, irq_source_out, 1'b0}) // R16
    else $error("vector does not match source");
  a_unselected_drop: assert property (cur_ff.choice_ff && !ext_irq_three_in
    && !cur_ff.latch_ff[11] |=> !cur_ff.latch_ff[11]) // R18
    else $error("unselected shared source latched");
  a_trap_select: assert property (trap_output_select_in && !cur_ff.latch_ff[2]
    |=> !cur_ff.latch_ff[2]) // R23
    else $error("trap latched while routed to reset");
  a_watchdog_select: assert property (watchdog_output_select_in && !cur_ff.latch_ff[3]
    |=> !cur_ff.latch_ff[3]) // R23
    else $error("watchdog latched while routed to reset");

  // Register side: zeros clear, ones never set, a hardware set beats a clear
  sequence s_clear_low5;
    wr_pend_low && !sfr_wdata_in[5];
  endsequence

  a_clear_lands: assert property (s_clear_low5 ##0 !set_vec[5]
    |=> !cur_ff.latch_ff[5]) // R5
    else $error("written zero did not clear latch");
  a_high_one_ignored: assert property (wr_pend_high && (set_vec[15:8] == 8'h00)
    |=> (cur_ff.latch_ff[15:8] & ~$past(cur_ff.latch_ff[15:8])) == 8'h00) // R4
    else $error("software write set a high latch");
  a_set_beats_clear: assert property (wr_pend_high && !sfr_wdata_in[0] && set_vec[8]
    |=> cur_ff.latch_ff[8]) // R1
    else $error("clearing write beat a hardware set");
  a_latch_holds: assert property (cur_ff.latch_ff[10] && !wr_pend_high
    && !(accept && (cur_ff.idx_ff == 4'hA)) |=> cur_ff.latch_ff[10]) // R24
    else $error("pending latch lost without clear");
  a_pending_read: assert property (sfr_rd_in && (sfr_addr_in == `PENDING_HIGH_ADDR)
    |=> sfr_rdata_out == $past(cur_ff.latch_ff[15:8])) // R5
    else $error("pending byte read wrong");

  // Flags: a write only counts when no instruction or acceptance outranks it
  sequence s_master_quiet;
    !accept && !return_instr_in && !master_on_instr_in && !master_off_instr_in;
  endsequence

  a_enable_write: assert property (wr_en_high
    |=> cur_ff.enable_ff[15:8] == $past(sfr_wdata_in)) // R12 R22
    else $error("enable byte not stored");
  a_master_write: assert property (wr_en_low ##0 s_master_quiet
    |=> cur_ff.master_ff == $past(sfr_wdata_in[`MASTER_BIT])) // R11
    else $error("master flag write lost");
  a_master_on: assert property (master_on_instr_in && !accept && !return_instr_in
    && !master_off_instr_in |=> cur_ff.master_ff) // R11
    else $error("enable instruction did not set master flag");
  a_master_off: assert property (master_off_instr_in && !accept && !return_instr_in
    |=> !cur_ff.master_ff) // R11
    else $error("disable instruction did not clear master flag");
  a_flag_blocks: assert property (!cur_ff.enable_ff[9]
    |=> !(irq_request_out && (irq_source_out == 4'h9))) // R12
    else $error("disabled source presented");
  a_pin_gate: assert property (!ext_zero_pin_enable_in
    |=> !(irq_request_out && (irq_source_out == `FIRST_MASKABLE))) // R26
    else $error("source four presented with pin disabled");

  // Routing, priority and vectors
  a_shared_route: assert property (!cur_ff.choice_ff && timer4_irq_in
    |=> cur_ff.latch_ff[`SHARED_LATCH]) // R17
    else $error("selected timer request not latched");
  a_ext3_route: assert property (cur_ff.choice_ff && ext_irq_three_in
    |=> cur_ff.latch_ff[`SHARED_LATCH]) // R17
    else $error("selected external request not latched");
  a_priority_order: assert property (active[5]
    |=> irq_request_out && (irq_source_out <= 4'h5)) // R14
    else $error("lower priority source won");
  a_swi_vector: assert property (software_trap_irq_in
    |=> irq_request_out && (irq_source_out == 4'h1) && (irq_vector_out == 16'hFFFC)) // R15
    else $error("software trap not presented at its vector");
  a_trap_vector: assert property (irq_request_out && (irq_source_out == `TRAP_LATCH)
    |-> irq_vector_out == 16'hFFFA) // R15
    else $error("trap vector wrong");
  a_watchdog_vector: assert property (irq_request_out && (irq_source_out == `WATCHDOG_LATCH)
    |-> irq_vector_out == 16'hFFF8) // R15
    else $error("watchdog vector wrong");
  a_first_vector: assert property (irq_request_out && (irq_source_out == `FIRST_MASKABLE)
    |-> irq_vector_out == 16'hFFF6) // R16
    else $error("first maskable vector wrong");
  a_lowest_vector: assert property (irq_request_out && (irq_source_out == 4'hF)
    |-> irq_vector_out == 16'hFFE0) // R16
    else $error("last maskable vector wrong");
endmodule

//--- prioritized_interrupt_controller_test.sv
// Self-checking bench: random traffic against a cycle mirror of the controller
`timescale 1ns/1ps
module prioritized_interrupt_controller_test import irq_ctrl_pkg::*;;
  logic        clk, rst_n, wr, rd, mon, moff, sw, bo, ta, ts, wi, wsel, x3, pe, rc;
  logic        req, sav, acc, ret, rest, mst, sel, e_req, e_sav;
  logic [7:0]  addr, wd, rdata, e_rd;
  logic [15:4] src;
  logic [2:0]  wt;
  logic [15:0] vec, lat, en;
  logic [3:0]  sid, e_src;
  int          seed = 61032;
  int          bad_count, checks_done, r, d, k, i, j, w;
  logic [7:0]  amap[6] = '{8'h3A, 8'h3B, 8'h3C, 8'h3D, 8'h3E, 8'h40};

  prioritized_interrupt_controller prioritized_interrupt_controller_i (
    .clk_in(clk), .rst_n_in(rst_n), .sfr_addr_in(addr), .sfr_wr_in(wr), .sfr_rd_in(rd),
    .sfr_wdata_in(wd), .sfr_rdata_out(rdata), .master_on_instr_in(mon),
    .master_off_instr_in(moff), .return_instr_in(ret), .restored_master_in(rest),
    .irq_accept_in(acc), .irq_request_out(req), .irq_vector_out(vec), .irq_source_out(sid),
    .saved_master_out(sav), .software_trap_irq_in(sw), .bad_opcode_irq_in(bo),
    .fetch_area_trap_irq_in(ta), .trap_output_select_in(ts), .watchdog_irq_in(wi),
    .watchdog_output_select_in(wsel), .ext_irq_zero_in(src[4]), .ext_zero_pin_enable_in(pe),
    .ext_irq_one_in(src[5]), .time_base_irq_in(src[6]), .timer1_irq_in(src[7]),
    .serial_receive_irq_in(src[8]), .serial_transmit_irq_in(src[9]), .timer3_irq_in(src[10]),
    .timer4_irq_in(src[11]), .ext_irq_three_in(x3), .converter_done_irq_in(src[12]),
    .serial_expansion_irq_in(src[13]), .ext_irq_four_in(src[14]), .ext_irq_five_in(src[15]));

  cpu_partner_model cpu_partner_model_i (
    .clk_in(clk), .rst_n_in(rst_n), .request_in(req), .saved_in(sav), .wait_in(wt),
    .ret_cmd_in(rc), .accept_out(acc), .return_out(ret), .restored_out(rest));

  // Free-running system clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // Source presented by the mirror, lowest index wins
  function automatic logic act(input int n);
    if (n == 1) return sw | bo;
    if (n < 4) return lat[n];
    return lat[n] & en[n] & mst & (n != 4 || pe);
  endfunction

  // Expected read data of a register address
  function automatic logic [7:0] rdv(input logic [7:0] a);
    case (a)
      8'h3A: return {en[7:4], 3'h0, mst};
      8'h3B: return en[15:8];
      8'h3C: return {lat[7:2], 2'h0};
      8'h3D: return lat[15:8];
      8'h3E: return {3'h0, sel, 4'h0};
      default: return 8'h00;
    endcase
  endfunction

  task automatic check(input string n, input logic [15:0] e, input logic [15:0] g);
    checks_done++;
    if (e !== g) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic wrap_up();
    $display("Checks %0d, mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Cycle mirror: pick from pre-edge state, then apply clears, then sets (set wins)
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lat = 16'h0000;
      en = 16'h0000;
      mst = 1'b0;
      sel = 1'b0;
      e_req = 1'b0;
      e_src = 4'h0;
      e_sav = 1'b0;
      e_rd = 8'h00;
    end else begin
      w = 0;
      for (i = 15; i >= 1; i--) begin
        if (act(i)) w = i;
      end
      if (rd) e_rd = rdv(addr);
      if (acc && e_req && e_src >= 2) lat[e_src] = 1'b0;
      if (acc && e_req) e_sav = mst;
      if (wr && addr == 8'h3C) lat[7:2] = lat[7:2] & wd[7:2];
      if (wr && addr == 8'h3D) lat[15:8] = lat[15:8] & wd;
      if (wr && addr == 8'h3A) en[7:4] = wd[7:4];
      if (wr && addr == 8'h3B) en[15:8] = wd;
      if (acc && e_req) mst = 1'b0;
      else if (ret) mst = rest;
      else if (mon) mst = 1'b1;
      else if (moff) mst = 1'b0;
      else if (wr && addr == 8'h3A) mst = wd[0];
      lat[11] = lat[11] | (src[11] & ~sel) | (x3 & sel);
      lat[15:12] = lat[15:12] | src[15:12];
      lat[10:4] = lat[10:4] | src[10:4];
      lat[2] = lat[2] | (ta & ~ts);
      lat[3] = lat[3] | (wi & ~wsel);
      if (wr && addr == 8'h3E) sel = wd[4];
      e_req = (w != 0);
      if (w != 0) e_src = w[3:0];
    end
  end

  // Outputs against the mirror once per cycle, away from the launching edge
  always @(negedge clk) begin
    if (rst_n) begin
      check("request", {15'h0000, e_req}, {15'h0000, req});
      if (e_req) check("vector", 16'hFFFE - {11'h000, e_src, 1'b0}, vec);
      if (e_req) check("source", {12'h000, e_src}, {12'h000, sid});
      check("saved", {15'h0000, e_sav}, {15'h0000, sav});
      check("rdata", {8'h00, e_rd}, {8'h00, rdata});
    end
  end

  // Hang guard well past the expected run length
  initial begin
    #(20 * 6000);
    bad_count++;
    wrap_up();
  end

  // Reset, read every register, then random traffic on all inputs
  initial begin
    {rst_n, wr, rd, mon, moff, sw, bo, ta, wi, x3, pe, rc} = 12'h000;
    {ts, wsel} = 2'h3;
    addr = 8'h00;
    wd = 8'h00;
    src = 12'h000;
    wt = 3'h0;
    bad_count = 0;
    checks_done = 0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    wr <= 1'b1;
    addr <= 8'h3E;
    wd <= 8'h10;
    for (k = 0; k < 6; k++) begin
      @(posedge clk);
      wr <= 1'b0;
      rd <= 1'b1;
      addr <= amap[k];
    end
    for (k = 0; k < 4000; k++) begin
      @(posedge clk);
      r = $random(seed);
      d = $random(seed);
      j = r[6:4] % 6;
      rst_n <= (k < 2000) || (k > 2002);
      rd <= r[9:8] == 2'h1;
      wr <= r[9:8] == 2'h0;
      addr <= amap[j];
      wd <= (j == 2) ? (d[7:0] | 8'h0C) : (j == 4) ? (d[7:0] & 8'hDF) : d[7:0];
      mon <= r[12:10] == 3'h1;
      moff <= r[12:10] == 3'h2;
      rc <= r[12:10] == 3'h3;
      wt <= r[15:13];
      ts <= r[16];
      wsel <= r[17];
      pe <= r[18] | r[19];
      src <= (r[27:24] == 4'h0) ? (d[23:12] & d[31:20]) : 12'h000;
      x3 <= (r[27:24] == 4'h0) & d[8];
      ta <= (r[27:24] == 4'h0) & d[9] & d[10];
      wi <= (r[27:24] == 4'h0) & d[10] & d[11];
      if (acc) begin
        sw <= 1'b0;
        bo <= 1'b0;
      end else if (r[31:28] == 4'h0) begin
        sw <= r[0];
        bo <= r[1];
      end
    end
    wrap_up();
  end
endmodule
